// ==== verilog/wdc_top.sv ====
// watchpoint compare, debug control/status, scan register access
`timescale 1ns/100ps
module wdc_top #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	input  wire logic          clk_sys,
	input  wire logic          nrst,
	input  wire logic          tck,
	input  wire logic          ntrst,
	input  wire logic          tdi,
	input  wire logic          scan_capture,
	input  wire logic          scan_shift,
	input  wire logic          scan_update,
	output logic               tdo,
	input  wire logic [AW-1:0] data_addr,
	input  wire logic [DW-1:0] data_value,
	input  wire logic          access_direction_n,
	input  wire logic [1:0]    data_access_size,
	input  wire logic          data_translate,
	input  wire logic          data_valid,
	input  wire logic [AW-1:0] instr_addr,
	input  wire logic [DW-1:0] instr_data,
	input  wire logic          instr_translate,
	input  wire logic          fetch_valid,
	input  wire logic          exception_entry,
	input  wire logic          compressed_state_flag,
	input  wire logic          external_condition_unit0,
	input  wire logic          external_condition_unit1,
	input  wire logic          halt_request_in,
	input  wire logic          halt_acknowledge_out,
	input  wire logic          irq_enable_state,
	input  wire logic          system_access_done,
	output logic               watchpoint_hit,
	output logic               breakpoint_hit,
	output logic               single_step_en,
	output logic               force_halt_request,
	output logic               force_halt_ack,
	output logic               irq_disable
);
	logic [wdc_pkg::WDC_NSYNC-1:0]   sync_in;
	logic [wdc_pkg::WDC_NSYNC-1:0]   sync_q;
	logic                            tck_s;
	logic                            ntrst_s;
	logic                            tdi_s;
	logic                            capture_s;
	logic                            shift_s;
	logic                            update_s;
	logic                            req_s;
	logic                            ack_s;
	logic                            irqen_s;
	logic                            sysdone_s;
	logic                            tck_d;
	logic                            tck_rise;
	logic                            ack_d;
	logic [wdc_pkg::WDC_CHAIN_W-1:0] chain;
	logic [4:0]                      ch_addr;
	logic                            ch_write;
	logic                            upd_hit;
	logic [wdc_pkg::WDC_DCTRL_W-1:0] debug_control;
	logic [wdc_pkg::WDC_VCATCH_W-1:0] vector_catch;
	logic [wdc_pkg::WDC_DSTAT_W-1:0] debug_status;
	logic [31:0]                     rd_mux;
	logic [31:0]                     u0_rd;
	logic [31:0]                     u1_rd;
	logic                            u0_wr;
	logic                            u1_wr;
	logic [4:0]                      d_ctrl;
	logic [4:0]                      i_ctrl;
	logic                            u0_mode;
	logic                            u1_mode;
	logic                            u0_hit;
	logic                            u1_hit;
	logic                            u1_span;
	logic                            u1_link;
	logic                            u0_span;
	logic                            u0_link;
	logic                            vec_hit;
	logic                            step_hit;
	wdc_pkg::wdc_step_e              step_state;
	wdc_pkg::wdc_step_e              next_step_state;

	// scan pins and core status levels come from other domains
	assign sync_in = {system_access_done, irq_enable_state, halt_acknowledge_out,
		halt_request_in, scan_update, scan_shift, scan_capture, tdi, ntrst, tck};
	wdc_sync #(
		.W(wdc_pkg::WDC_NSYNC)
	) u_sync (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.async_in (sync_in),
		.sync_out (sync_q)
	);
	assign {sysdone_s, irqen_s, ack_s, req_s, update_s, shift_s, capture_s, tdi_s, ntrst_s,
		tck_s} = sync_q;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tck_d <= 1'b0;
			ack_d <= 1'b0;
		end else begin
			tck_d <= tck_s;
			ack_d <= ack_s;
		end
	end
	assign tck_rise = tck_s & ~tck_d;

	assign ch_addr  = chain[wdc_pkg::WDC_CH_ADDR_LO +: wdc_pkg::WDC_AW];
	assign ch_write = chain[wdc_pkg::WDC_CH_RW];
	assign upd_hit  = tck_rise & update_s & ch_write;
	assign u0_wr    = upd_hit & (ch_addr[4:3] == wdc_pkg::WDC_UNIT0_SEL);
	assign u1_wr    = upd_hit & (ch_addr[4:3] == wdc_pkg::WDC_UNIT1_SEL);

	// status: ack, req, interrupt enable, access done, instruction state
	// ack is taken synchronised so bit 2 never sees a half-settled level
	assign debug_status = {compressed_state_flag, sysdone_s, irqen_s & ~ack_s, req_s, ack_s};

	always_comb begin
		rd_mux = '0;
		case (ch_addr)
			wdc_pkg::WDC_A_DBG_CTRL: rd_mux[wdc_pkg::WDC_DCTRL_W-1:0] = debug_control;
			wdc_pkg::WDC_A_DBG_STAT: rd_mux[wdc_pkg::WDC_DSTAT_W-1:0] = debug_status;
			wdc_pkg::WDC_A_VCATCH:   rd_mux[wdc_pkg::WDC_VCATCH_W-1:0] = vector_catch;
			default: begin
				if (ch_addr[4:3] == wdc_pkg::WDC_UNIT0_SEL)
					rd_mux = u0_rd;
				else if (ch_addr[4:3] == wdc_pkg::WDC_UNIT1_SEL)
					rd_mux = u1_rd;
				else
					rd_mux = '0;
			end
		endcase
	end

	// scan chain: capture loads data, shift moves toward tdo
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			chain <= '0;
			tdo   <= 1'b0;
		end else if (tck_rise && capture_s) begin
			chain[wdc_pkg::WDC_DW-1:0] <= rd_mux;
			tdo <= rd_mux[0];
		end else if (tck_rise && shift_s) begin
			chain <= {tdi_s, chain[wdc_pkg::WDC_CHAIN_W-1:1]};
			tdo   <= chain[1];
		end
	end

	// only debug control and vector catch take writes; status ignores them
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			debug_control <= '0;
			vector_catch  <= '0;
		end else if (upd_hit) begin
			if (ch_addr == wdc_pkg::WDC_A_DBG_CTRL)
				debug_control <= chain[wdc_pkg::WDC_DCTRL_W-1:0];
			if (ch_addr == wdc_pkg::WDC_A_VCATCH)
				vector_catch <= chain[wdc_pkg::WDC_VCATCH_W-1:0];
		end
	end

	// observed control: {privilege, mode, state or size hi, size lo, direction} per side
	assign d_ctrl = {data_translate, 1'b1, data_access_size, access_direction_n};
	// bits 1:0 carry no information here, software masks them
	assign i_ctrl = {instr_translate, 1'b0, compressed_state_flag, 2'b00};

	wdc_unit #(
		.AW(AW),
		.DW(DW)
	) u_wp1 (
		.clk_sys        (clk_sys),
		.nrst           (nrst),
		.wr_en          (u1_wr),
		.wr_idx         (ch_addr[2:0]),
		.wr_data        (chain[31:0]),
		.rd_idx         (ch_addr[2:0]),
		.test_reset     (~ntrst_s),
		.d_addr         (data_addr),
		.d_data         (data_value),
		.d_ctrl         (d_ctrl),
		.d_valid        (data_valid),
		.i_addr         (instr_addr),
		.i_data         (instr_data),
		.i_ctrl         (i_ctrl),
		.i_valid        (fetch_valid),
		.ext_in         (external_condition_unit1),
		.chain_in       (1'b0),
		.range_in       (1'b0),
		.rd_data        (u1_rd),
		.data_mode      (u1_mode),
		.hit            (u1_hit),
		.span_out       (u1_span),
		.link_out_latch (u1_link)
	);

	// unit 1 feeds unit 0's chain and range positions
	wdc_unit #(
		.AW(AW),
		.DW(DW)
	) u_wp0 (
		.clk_sys        (clk_sys),
		.nrst           (nrst),
		.wr_en          (u0_wr),
		.wr_idx         (ch_addr[2:0]),
		.wr_data        (chain[31:0]),
		.rd_idx         (ch_addr[2:0]),
		.test_reset     (~ntrst_s),
		.d_addr         (data_addr),
		.d_data         (data_value),
		.d_ctrl         (d_ctrl),
		.d_valid        (data_valid),
		.i_addr         (instr_addr),
		.i_data         (instr_data),
		.i_ctrl         (i_ctrl),
		.i_valid        (fetch_valid),
		.ext_in         (external_condition_unit0),
		.chain_in       (u1_link),
		.range_in       (u1_span),
		.rd_data        (u0_rd),
		.data_mode      (u0_mode),
		.hit            (u0_hit),
		.span_out       (u0_span),
		.link_out_latch (u0_link)
	);

	// vector fetch during exception entry, bit picked by vector number
	assign vec_hit = fetch_valid & exception_entry
		& (instr_addr[AW-1:wdc_pkg::WDC_VEC_MSB+1] == '0)
		& vector_catch[instr_addr[wdc_pkg::WDC_VEC_MSB:wdc_pkg::WDC_VEC_LSB]];

	// single step: armed on leaving debug, breaks on the fetch after one instruction
	always_comb begin
		next_step_state = step_state;
		case (step_state)
			wdc_pkg::WDC_STEP_IDLE:
				if (ack_d && !ack_s && debug_control[wdc_pkg::WDC_DC_STEP])
					next_step_state = wdc_pkg::WDC_STEP_ARMED;
			wdc_pkg::WDC_STEP_ARMED:
				if (ack_s)
					next_step_state = wdc_pkg::WDC_STEP_IDLE;
				else if (fetch_valid)
					next_step_state = wdc_pkg::WDC_STEP_RUN;
			wdc_pkg::WDC_STEP_RUN:
				if (ack_s || fetch_valid)
					next_step_state = wdc_pkg::WDC_STEP_IDLE;
			default: next_step_state = wdc_pkg::WDC_STEP_IDLE;
		endcase
	end
	assign step_hit = (step_state == wdc_pkg::WDC_STEP_RUN) & fetch_valid & ~ack_s;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			step_state <= wdc_pkg::WDC_STEP_IDLE;
		else
			step_state <= next_step_state;
	end

	// hits steer watchpoint in data mode, breakpoint in instruction mode
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			watchpoint_hit <= 1'b0;
			breakpoint_hit <= 1'b0;
		end else begin
			watchpoint_hit <= (u0_hit & u0_mode) | (u1_hit & u1_mode);
			breakpoint_hit <= (u0_hit & ~u0_mode) | (u1_hit & ~u1_mode) | vec_hit | step_hit;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			single_step_en     <= 1'b0;
			force_halt_request <= 1'b0;
			force_halt_ack     <= 1'b0;
			irq_disable        <= 1'b0;
		end else begin
			single_step_en     <= debug_control[wdc_pkg::WDC_DC_STEP];
			force_halt_request <= debug_control[wdc_pkg::WDC_DC_REQ];
			force_halt_ack     <= debug_control[wdc_pkg::WDC_DC_ACK];
			irq_disable        <= debug_control[wdc_pkg::WDC_DC_IRQDIS];
		end
	end

	property p_data_watch;
		@(posedge clk_sys) disable iff (!nrst) u0_hit && u0_mode |=> watchpoint_hit;
	endproperty
	a_data_watch: assert property (p_data_watch) else $error("data hit lost");

	property p_instr_break;
		@(posedge clk_sys) disable iff (!nrst) u0_hit && !u0_mode |=> breakpoint_hit;
	endproperty
	a_instr_break: assert property (p_instr_break) else $error("instruction hit lost");

	property p_status_ro;
		@(posedge clk_sys) disable iff (!nrst)
			upd_hit && ch_addr == wdc_pkg::WDC_A_DBG_STAT |=> $stable(debug_control)
			&& $stable(vector_catch);
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status write took effect");

	property p_ctrl_write;
		@(posedge clk_sys) disable iff (!nrst)
			upd_hit && ch_addr == wdc_pkg::WDC_A_DBG_CTRL |=> debug_control == $past(chain[3:0])
			##1 single_step_en == debug_control[3];
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("debug control write wrong");

	property p_status_capture;
		@(posedge clk_sys) disable iff (!nrst)
			tck_rise && capture_s && ch_addr == wdc_pkg::WDC_A_DBG_STAT
			|=> chain[4:0] == $past(debug_status) && chain[31:5] == '0;
	endproperty
	a_status_capture: assert property (p_status_capture) else $error("status capture wrong");

	property p_step_break;
		@(posedge clk_sys) disable iff (!nrst)
			step_state == wdc_pkg::WDC_STEP_RUN && fetch_valid && !ack_s |=> breakpoint_hit;
	endproperty
	a_step_break: assert property (p_step_break) else $error("step did not break");

	property p_vec_catch;
		@(posedge clk_sys) disable iff (!nrst) vec_hit |=> breakpoint_hit;
	endproperty
	a_vec_catch: assert property (p_vec_catch) else $error("vector catch missed");

	property p_chain_feed;
		@(posedge clk_sys) disable iff (!nrst)
			$rose(u1_link) |-> $past(u1_span) && $past(ntrst_s);
	endproperty
	a_chain_feed: assert property (p_chain_feed) else $error("chain latch set without match");

	c_watch: cover property (@(posedge clk_sys) disable iff (!nrst) watchpoint_hit);
	c_step: cover property (@(posedge clk_sys) disable iff (!nrst)
		step_state == wdc_pkg::WDC_STEP_RUN ##1 breakpoint_hit);
	c_chain: cover property (@(posedge clk_sys) disable iff (!nrst) u1_link && u0_hit);
endmodule // wdc_top

// ==== include/wdc_pkg.sv ====
// constants and types for the watchpoint compare and debug register block
package wdc_pkg;
	// scan chain layout: data field, register address, direction
	localparam int WDC_DW           = 32;
	localparam int WDC_AW           = 5;
	localparam int WDC_CHAIN_W      = WDC_DW + WDC_AW + 1;
	localparam int WDC_CH_ADDR_LO   = WDC_DW;
	localparam int WDC_CH_RW        = WDC_DW + WDC_AW;
	// register addresses on the scan chain
	localparam logic [4:0] WDC_A_DBG_CTRL = 5'h00;
	localparam logic [4:0] WDC_A_DBG_STAT = 5'h01;
	localparam logic [4:0] WDC_A_VCATCH   = 5'h02;
	localparam logic [1:0] WDC_UNIT0_SEL  = 2'h1;
	localparam logic [1:0] WDC_UNIT1_SEL  = 2'h2;
	// register index inside one watchpoint unit
	localparam logic [2:0] WDC_I_ADDR_VAL  = 3'h0;
	localparam logic [2:0] WDC_I_ADDR_MASK = 3'h1;
	localparam logic [2:0] WDC_I_DATA_VAL  = 3'h2;
	localparam logic [2:0] WDC_I_DATA_MASK = 3'h3;
	localparam logic [2:0] WDC_I_CTRL_VAL  = 3'h4;
	localparam logic [2:0] WDC_I_CTRL_MASK = 3'h5;
	// watch control field positions
	localparam int WDC_CB_DIR    = 0;
	localparam int WDC_CB_SIZE   = 1;
	localparam int WDC_CB_STATE  = 2;
	localparam int WDC_CB_MODE   = 3;
	localparam int WDC_CB_PRIV   = 4;
	localparam int WDC_CB_EXT    = 5;
	localparam int WDC_CB_CHAIN  = 6;
	localparam int WDC_CB_RANGE  = 7;
	localparam int WDC_CB_ENABLE = 8;
	localparam int WDC_CVAL_W    = 9;
	localparam int WDC_CMASK_W   = 8;
	localparam logic [7:0] WDC_CMASK_WRITABLE = 8'hF7;
	// debug control, status and vector catch
	localparam int WDC_DCTRL_W    = 4;
	localparam int WDC_DC_REQ     = 0;
	localparam int WDC_DC_ACK     = 1;
	localparam int WDC_DC_IRQDIS  = 2;
	localparam int WDC_DC_STEP    = 3;
	localparam int WDC_DSTAT_W    = 5;
	localparam int WDC_VCATCH_W   = 8;
	localparam int WDC_VEC_LSB    = 2;
	localparam int WDC_VEC_MSB    = 4;
	// number of two-flop synchronised inputs
	localparam int WDC_NSYNC      = 10;
	typedef enum logic [2:0] {
		WDC_STEP_IDLE  = 3'b001,
		WDC_STEP_ARMED = 3'b010,
		WDC_STEP_RUN   = 3'b100
	} wdc_step_e;
endpackage

// ==== verilog/wdc_sync.sv ====
// two-flop synchroniser for a vector of independent levels
`timescale 1ns/100ps
module wdc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule // wdc_sync

// ==== verilog/wdc_unit.sv ====
// one watchpoint unit: value/mask registers, comparators, chain latch
`timescale 1ns/100ps
module wdc_unit #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	input  wire logic          clk_sys,
	input  wire logic          nrst,
	input  wire logic          wr_en,
	input  wire logic [2:0]    wr_idx,
	input  wire logic [31:0]   wr_data,
	input  wire logic [2:0]    rd_idx,
	input  wire logic          test_reset,
	input  wire logic [AW-1:0] d_addr,
	input  wire logic [DW-1:0] d_data,
	input  wire logic [4:0]    d_ctrl,
	input  wire logic          d_valid,
	input  wire logic [AW-1:0] i_addr,
	input  wire logic [DW-1:0] i_data,
	input  wire logic [4:0]    i_ctrl,
	input  wire logic          i_valid,
	input  wire logic          ext_in,
	input  wire logic          chain_in,
	input  wire logic          range_in,
	output logic [31:0]        rd_data,
	output logic               data_mode,
	output logic               hit,
	output logic               span_out,
	output logic               link_out_latch
);
	logic [AW-1:0]                   addr_val;
	logic [AW-1:0]                   addr_mask;
	logic [DW-1:0]                   data_val;
	logic [DW-1:0]                   data_mask;
	logic [wdc_pkg::WDC_CVAL_W-1:0]  ctrl_val;
	logic [wdc_pkg::WDC_CMASK_W-1:0] ctrl_mask;
	logic [AW-1:0]                   obs_addr;
	logic [DW-1:0]                   obs_data;
	logic [7:0]                      obs_ctrl;
	logic                            obs_valid;
	logic                            addr_hit;
	logic                            ctrl_hit;
	logic                            data_hit;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			addr_val  <= '0;
			addr_mask <= '0;
			data_val  <= '0;
			data_mask <= '0;
			ctrl_val  <= '0;
			ctrl_mask <= '0;
		end else if (wr_en) begin
			case (wr_idx)
				wdc_pkg::WDC_I_ADDR_VAL:  addr_val  <= wr_data[AW-1:0];
				wdc_pkg::WDC_I_ADDR_MASK: addr_mask <= wr_data[AW-1:0];
				wdc_pkg::WDC_I_DATA_VAL:  data_val  <= wr_data[DW-1:0];
				wdc_pkg::WDC_I_DATA_MASK: data_mask <= wr_data[DW-1:0];
				wdc_pkg::WDC_I_CTRL_VAL:  ctrl_val  <= wr_data[wdc_pkg::WDC_CVAL_W-1:0];
				// mode bit can never be masked, enable has no mask bit
				wdc_pkg::WDC_I_CTRL_MASK: ctrl_mask <= wr_data[7:0] & wdc_pkg::WDC_CMASK_WRITABLE;
				default: ;
			endcase
		end
	end

	// mode bit picks data side (1) or instruction side (0)
	assign data_mode = ctrl_val[wdc_pkg::WDC_CB_MODE];
	assign obs_addr  = data_mode ? d_addr : i_addr;
	assign obs_data  = data_mode ? d_data : i_data;
	assign obs_valid = data_mode ? d_valid : i_valid;
	// extern, chain and range positions
	assign obs_ctrl  = {range_in, chain_in, ext_in, (data_mode ? d_ctrl : i_ctrl)};

	// a set mask bit drops that position; all others must agree
	assign addr_hit = &(~(addr_val ^ obs_addr) | addr_mask);
	assign data_hit = &(~(data_val ^ obs_data) | data_mask);
	assign ctrl_hit = &(~(ctrl_val[7:0] ^ obs_ctrl) | ctrl_mask);
	assign span_out = obs_valid & addr_hit;
	assign hit = obs_valid & addr_hit & ctrl_hit & data_hit & ctrl_val[wdc_pkg::WDC_CB_ENABLE];

	// chain latch: address/control match enables, data match is stored
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			link_out_latch <= 1'b0;
		else if (test_reset || (wr_en && wr_idx == wdc_pkg::WDC_I_CTRL_VAL))
			link_out_latch <= 1'b0;
		else if (obs_valid && addr_hit && ctrl_hit)
			link_out_latch <= data_hit;
	end

	always_comb begin
		rd_data = '0;
		case (rd_idx)
			wdc_pkg::WDC_I_ADDR_VAL:  rd_data[AW-1:0] = addr_val;
			wdc_pkg::WDC_I_ADDR_MASK: rd_data[AW-1:0] = addr_mask;
			wdc_pkg::WDC_I_DATA_VAL:  rd_data[DW-1:0] = data_val;
			wdc_pkg::WDC_I_DATA_MASK: rd_data[DW-1:0] = data_mask;
			wdc_pkg::WDC_I_CTRL_VAL:  rd_data[wdc_pkg::WDC_CVAL_W-1:0] = ctrl_val;
			wdc_pkg::WDC_I_CTRL_MASK: rd_data[wdc_pkg::WDC_CMASK_W-1:0] = ctrl_mask;
			default: rd_data = '0;
		endcase
	end

	property p_mode_unmasked;
		@(posedge clk_sys) disable iff (!nrst) ctrl_mask[wdc_pkg::WDC_CB_MODE] == 1'b0;
	endproperty
	a_mode_unmasked: assert property (p_mode_unmasked) else $error("mode mask bit set");

	property p_link_clear;
		@(posedge clk_sys) disable iff (!nrst)
			(wr_en && wr_idx == wdc_pkg::WDC_I_CTRL_VAL) || test_reset |=> !link_out_latch;
	endproperty
	a_link_clear: assert property (p_link_clear) else $error("chain latch not cleared");

	property p_enable_gate;
		@(posedge clk_sys) disable iff (!nrst) hit |-> ctrl_val[wdc_pkg::WDC_CB_ENABLE] && addr_hit;
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("hit without enable");
endmodule // wdc_unit

// ==== verif/wdc_scan_host.sv ====
// scan debugger model: 38-bit frames on a tck that only runs inside frames
`timescale 1ns/100ps
module wdc_scan_host (
	input  wire logic clk_sys,
	input  wire logic tdo,
	output logic      tck,
	output logic      tdi,
	output logic      scan_capture,
	output logic      scan_shift,
	output logic      scan_update
);
	initial {tck, tdi, scan_capture, scan_shift, scan_update} = 5'h00;
	// half of the 160 ns tck, launched just after clk_sys
	task automatic half();
		repeat (20) @(posedge clk_sys);
		#1;
	endtask
	task automatic rise();
		half();
		tck = 1'b1;
		half();
		tck = 1'b0;
	endtask
	// previous capture comes out while the new frame goes in
	task automatic frame(input logic [37:0] f, output logic [37:0] q);
		scan_shift = 1'b1;
		for (int i = 0; i < 38; i++) begin
			tdi = f[i];
			half();
			q[i] = tdo;
			tck = 1'b1;
			half();
			tck = 1'b0;
		end
		scan_shift = 1'b0;
		// released line must not keep the last bit
		tdi = ~tdi;
		scan_update = 1'b1;
		rise();
		scan_update = 1'b0;
		scan_capture = 1'b1;
		rise();
		scan_capture = 1'b0;
	endtask
endmodule // wdc_scan_host

// ==== verif/tb_wdc_top.sv ====
// self-checking bench: scan register access and watchpoint compares
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_wdc_top;
	logic clk_sys = 0, nrst = 0, tck, tdi, cap, sh, upd, tdo, wh, bh, sse;
	logic dir = 0, dtr = 0, dvl = 0, itr = 0, fv = 0, cf = 1, e0 = 0, rq = 1, ack = 0;
	logic ntr = 1, xe = 0;
	logic [1:0] sz = 0;
	logic [31:0] da = 0, ia = 0, r;
	int error_cnt = 0, total_checks = 0, cyc = 0;
	always #2 clk_sys = ~clk_sys;
	wdc_scan_host i_wdc_scan_host (.clk_sys(clk_sys), .tdo(tdo), .tck(tck), .tdi(tdi),
		.scan_capture(cap), .scan_shift(sh), .scan_update(upd));
	wdc_top i_wdc_top (.clk_sys(clk_sys), .nrst(nrst), .tck(tck), .ntrst(ntr), .tdi(tdi),
		.scan_capture(cap), .scan_shift(sh), .scan_update(upd), .tdo(tdo),
		.data_addr(da), .data_value(32'hCAFE_0042), .access_direction_n(dir),
		.data_access_size(sz), .data_translate(dtr), .data_valid(dvl), .instr_addr(ia),
		.instr_data(32'h1357_9BDF), .instr_translate(itr), .fetch_valid(fv),
		.exception_entry(xe), .compressed_state_flag(cf), .external_condition_unit0(e0),
		.external_condition_unit1(1'b0), .halt_request_in(rq), .halt_acknowledge_out(ack),
		.irq_enable_state(1'b1), .system_access_done(1'b1), .watchpoint_hit(wh),
		.breakpoint_hit(bh), .single_step_en(sse), .force_halt_request(),
		.force_halt_ack(), .irq_disable());
	task automatic final_report();
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [37:0] q;
		i_wdc_scan_host.frame({1'b1, a, d}, q);
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		logic [37:0] q;
		i_wdc_scan_host.frame({1'b0, a, 32'h0000_0000}, q);
		i_wdc_scan_host.frame({1'b0, a, 32'h0000_0000}, q);
		d = q[31:0];
	endtask
	// f packs ext, privilege, size, direction
	task automatic dcyc(input logic [4:0] f, input logic [31:0] a, input logic x);
		@(posedge clk_sys);
		#1;
		{e0, dtr, sz, dir} = f;
		da = a;
		dvl = 1'b1;
		@(posedge clk_sys);
		#1;
		dvl = 1'b0;
		`CHK(wh, x)
	endtask
	task automatic icyc(input logic c, input logic t, input logic x);
		@(posedge clk_sys);
		#1;
		{cf, itr, fv} = {c, t, 1'b1};
		ia = 32'h0000_0A00;
		@(posedge clk_sys);
		#1;
		fv = 1'b0;
		`CHK(bh, x)
	endtask
	// fetch from the vector area, with or without exception entry
	task automatic vcyc(input logic x_en, input logic x);
		@(posedge clk_sys);
		#1;
		{xe, fv} = {x_en, 1'b1};
		ia = 32'h0000_0008;
		@(posedge clk_sys);
		#1;
		{xe, fv} = 2'b00;
		`CHK(bh, x)
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		#1;
		nrst = 1'b1;
		wr(5'h00, 32'hFFFF_FFFF);
		rd(5'h00, r);
		`CHK(r, 32'h0000_000F)
		`CHK(sse, 1'b1)
		rd(5'h01, r);
		`CHK(r, 32'h0000_001E)
		wr(5'h01, 32'h0000_0000);
		ack = 1'b1;
		// acknowledge also gates the interrupt enable bit off
		rd(5'h01, r);
		`CHK(r, 32'h0000_001B)
		wr(5'h08, 32'h0000_1234);
		wr(5'h0A, 32'hCAFE_0042);
		wr(5'h0C, 32'h0000_011D);
		dcyc(5'h0D, 32'h0000_1234, 1'b1);
		dcyc(5'h0C, 32'h0000_1234, 1'b0);
		dcyc(5'h0B, 32'h0000_1234, 1'b0);
		dcyc(5'h05, 32'h0000_1234, 1'b0);
		dcyc(5'h1D, 32'h0000_1234, 1'b0);
		dcyc(5'h0D, 32'h0000_1235, 1'b0);
		wr(5'h0D, 32'h0000_0001);
		dcyc(5'h0C, 32'h0000_1234, 1'b1);
		wr(5'h0C, 32'h0000_001D);
		dcyc(5'h0D, 32'h0000_1234, 1'b0);
		wr(5'h0D, 32'h0000_00FF);
		rd(5'h0D, r);
		`CHK(r, 32'h0000_00F7)
		wr(5'h10, 32'h0000_0A00);
		wr(5'h12, 32'h1357_9BDF);
		wr(5'h15, 32'h0000_0003);
		wr(5'h14, 32'h0000_0114);
		icyc(1'b1, 1'b1, 1'b1);
		icyc(1'b0, 1'b1, 1'b0);
		icyc(1'b1, 1'b0, 1'b0);
		`CHK(i_wdc_top.u1_link, 1'b1)
		ntr = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		`CHK(i_wdc_top.u1_link, 1'b0)
		ntr = 1'b1;
		wr(5'h02, 32'h0000_0004);
		vcyc(1'b1, 1'b1);
		vcyc(1'b0, 1'b0);
		// leaving debug with step enabled: first fetch runs, second breaks
		ack = 1'b0;
		repeat (4) @(posedge clk_sys);
		vcyc(1'b0, 1'b0);
		vcyc(1'b0, 1'b1);
		final_report();
	end
endmodule // tb_wdc_top
